// ==== hw/desq_top.sv ====
// Purpose: executes branch, terminate, add and subtract directors
// Assumes: one pclk; internal clock pulses arrive as a one-cycle enable
// Notes: register file is internal, sixteen 16-bit entries
`timescale 1ns/1ps
module desq_top
   import desq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic internal_clock_tick,
   input wire logic director_request_pending,
   input wire logic director_write_timing_a,
   input wire logic director_write_timing_b,
   input wire logic read_in_progress,
   input wire logic [6:0] cond_flags,
   input wire logic chan_func_valid,
   input wire logic [3:0] chan_number,
   input wire logic [15:0] chan_func_code,
   output logic write_chain_disable,
   output logic branch_addr_to_mux,
   output logic branch_load,
   output logic load_director_address,
   output logic branch_flush,
   output logic erase_head_on,
   output logic branch_finish,
   output logic director_done,
   output logic branch_decode_enable,
   output logic director_run_enable,
   output logic [15:0] director_address_r
);
   // field extraction, bit 00 is the msb
   function automatic logic [7:0] op_of(input logic [31:0] d);
      op_of = d[31:24];
   endfunction

   logic [31:0] dir_r; // director word written by software
   logic go_r; // one-shot start pulse from control write
   logic [3:0] file_addr_r; // register file address counter
   logic [15:0] catch_r; // support catch register, operand b
   logic [15:0] alu_catch_r; // alu catching register
   logic [15:0] rfile [16]; // register file entries
   logic [15:0] branch_hold_r; // held branch address
   logic add_r, sub_r; // operation flags
   logic [3:0] alu_ph_r; // alu chain phase, 0 idle
   logic done_clr_r; // companion of director_done
   logic cbr_r; // branch active flag
   logic catch15_r, erase_en_r; // bit 15 and erase captures
   logic cond_r; // condition made, latched at decode
   desq_br_t br_r;
   logic [1:0] rt_r; // read timing step for terminate
   logic end_gate_r, ready_r; // end gate, support-director-ready
   logic sw_inhibit_r, sw_rd_busy_r; // software overrides of inhibits
   logic apb_wr, apb_rd, inh, rd_busy, tick;
   logic [15:0] file_bus;
   logic [16:0] alu_out;

   assign apb_wr = psel & penable & pwrite;
   assign apb_rd = psel & penable & ~pwrite;
   assign pready = 1'b1; // zero wait state slave
   assign tick = internal_clock_tick;
   assign inh = director_request_pending | director_write_timing_a |
                director_write_timing_b | sw_inhibit_r;
   assign rd_busy = read_in_progress | sw_rd_busy_r;
   // file idles in read mode: addressed entry is operand a
   assign file_bus = (alu_ph_r == DESQ_PH6 || alu_ph_r == DESQ_PH7) ?
                     alu_catch_r : rfile[file_addr_r];
   // add: a + b; subtract: a + ~b + carry in
   assign alu_out = sub_r ? ({1'b0, file_bus} + {1'b0, ~catch_r} + 17'd1)
                          : ({1'b0, file_bus} + {1'b0, catch_r});

   // apb read mux and error on unmapped address
   always_comb begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      case (paddr)
         DESQ_OFF_DIR: prdata = dir_r;
         DESQ_OFF_CTRL: prdata = {28'h000_0000, sw_rd_busy_r, sw_inhibit_r,
                                  2'b00};
         DESQ_OFF_STAT: prdata = {16'h0000, director_address_r};
         DESQ_OFF_FLAGS: prdata = {24'h00_0000, br_r, alu_ph_r,
                                   director_run_enable};
         DESQ_OFF_RESULT: prdata = {16'h0000, alu_catch_r};
         default: pslverr = apb_wr | apb_rd;
      endcase
   end

   // register writes; start is a one-cycle pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_r <= 32'h0000_0000;
         go_r <= 1'b0;
         sw_inhibit_r <= 1'b0;
         sw_rd_busy_r <= 1'b0;
      end else begin
         go_r <= 1'b0;
         if (apb_wr && paddr == DESQ_OFF_DIR) begin
            dir_r <= pwdata;
         end
         if (apb_wr && paddr == DESQ_OFF_CTRL) begin
            go_r <= pwdata[DESQ_CTRL_START];
            sw_inhibit_r <= pwdata[DESQ_CTRL_INHIBIT];
            sw_rd_busy_r <= pwdata[DESQ_CTRL_RD_BUSY];
         end
      end
   end

   // terminate and restart of director execution
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         director_run_enable <= 1'b1;
         end_gate_r <= 1'b0;
         ready_r <= 1'b1;
         rt_r <= 2'd0;
      end else begin
         if (go_r && director_run_enable &&
             op_of(dir_r) == DESQ_OP_TERM) begin
            ready_r <= 1'b0;
            end_gate_r <= 1'b1;
            rt_r <= 2'd0;
         end else if (end_gate_r && tick) begin
            // count read time steps up to time 300
            if (rt_r == DESQ_RT300) begin
               director_run_enable <= 1'b0;
               end_gate_r <= 1'b0;
            end else begin
               rt_r <= rt_r + 2'd1;
            end
         end
         // only the restart code on channel 8 reopens
         if (chan_func_valid && chan_number == DESQ_RESTART_CHAN &&
             chan_func_code == DESQ_RESTART_CODE) begin
            director_run_enable <= 1'b1;
            ready_r <= 1'b1;
         end
      end
   end

   // decode of add and subtract: load counter, catch, flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         file_addr_r <= 4'h0;
         catch_r <= 16'h0000;
         add_r <= 1'b0;
         sub_r <= 1'b0;
      end else if (go_r && director_run_enable && alu_ph_r == 4'd0 &&
                   (op_of(dir_r) == DESQ_OP_ADD ||
                    op_of(dir_r) == DESQ_OP_SUB)) begin
         file_addr_r <= dir_r[3:0]; // bits 28-31
         catch_r <= dir_r[23:8]; // bits 08-23
         sub_r <= op_of(dir_r) == DESQ_OP_SUB;
         add_r <= op_of(dir_r) == DESQ_OP_ADD;
      end else if (tick && alu_ph_r == DESQ_PH6) begin
         add_r <= 1'b0;
         sub_r <= 1'b0;
      end
   end

   // alu timing chain, eight phases on ticks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alu_ph_r <= 4'd0;
      end else if (tick) begin
         if (alu_ph_r == 4'd0) begin
            if (add_r || sub_r) begin
               alu_ph_r <= 4'd1;
            end
         end else if (alu_ph_r == DESQ_PH8) begin
            alu_ph_r <= 4'd0; // last stage cleared
         end else begin
            alu_ph_r <= alu_ph_r + 4'd1;
         end
      end
   end

   // result capture and register file write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alu_catch_r <= 16'h0000;
         for (int i = 0; i < 16; i++) begin
            rfile[i] <= 16'h0000;
         end
      end else if (tick) begin
         if (alu_ph_r == DESQ_PH5) begin
            alu_catch_r <= alu_out[15:0];
         end
         if (alu_ph_r == DESQ_PH7) begin
            // both byte enables and memory enable
            rfile[file_addr_r] <= file_bus;
         end
      end
   end

   // director done from either chain, companion clears itself
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         director_done <= 1'b0;
         done_clr_r <= 1'b0;
      end else begin
         if (tick && alu_ph_r == DESQ_PH7) begin
            director_done <= 1'b1;
            done_clr_r <= 1'b1;
         end else if (tick && alu_ph_r == DESQ_PH8) begin
            director_done <= 1'b0;
         end else if (tick && !inh && br_r == DESQ_BR_FIN) begin
            // an inhibited tick holds the finish step, so no early done
            director_done <= 1'b1;
            done_clr_r <= 1'b1;
         end else if (tick && br_r == DESQ_BR_CLRC) begin
            director_done <= 1'b0;
         end else if (done_clr_r && !director_done) begin
            done_clr_r <= 1'b0;
         end
      end
   end

   // branch chain: stage A, B, decision, load, finish, clear C
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         br_r <= DESQ_BR_IDLE;
         cbr_r <= 1'b0;
         catch15_r <= 1'b0;
         erase_en_r <= 1'b0;
         cond_r <= 1'b0;
         branch_hold_r <= 16'h0000;
      end else if (br_r == DESQ_BR_IDLE) begin
         if (go_r && director_run_enable &&
             op_of(dir_r) == DESQ_OP_BRANCH) begin
            cbr_r <= 1'b1;
            catch15_r <= dir_r[16]; // bit 15
            erase_en_r <= dir_r[16] & rd_busy;
            branch_hold_r <= dir_r[15:0]; // bits 16-31
            cond_r <= |(dir_r[23:17] & cond_flags);
            br_r <= DESQ_BR_A;
         end
      end else if (tick && !(inh && br_r != DESQ_BR_CLRC)) begin
         // inhibit holds any stage but clear C; else one step a tick
         case (br_r)
            DESQ_BR_A: begin
               // bit 15 waits out the read
               if (!(catch15_r && rd_busy)) br_r <= DESQ_BR_B;
            end
            DESQ_BR_B: br_r <= DESQ_BR_DEC;
            DESQ_BR_DEC: br_r <= DESQ_BR_LOAD;
            DESQ_BR_LOAD: br_r <= DESQ_BR_FIN;
            DESQ_BR_FIN: begin
               cbr_r <= 1'b0;
               br_r <= DESQ_BR_CLRC;
            end
            DESQ_BR_CLRC: br_r <= DESQ_BR_IDLE;
            default: br_r <= DESQ_BR_IDLE;
         endcase
      end
   end

   // branch outputs: decision levels and one-cycle strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_chain_disable <= 1'b0;
         branch_addr_to_mux <= 1'b0;
         branch_load <= 1'b0;
         load_director_address <= 1'b0;
         branch_flush <= 1'b0;
         erase_head_on <= 1'b0;
         branch_finish <= 1'b0;
         branch_decode_enable <= 1'b0;
         director_address_r <= 16'h0000;
      end else begin
         branch_load <= 1'b0;
         load_director_address <= 1'b0;
         branch_flush <= 1'b0;
         branch_finish <= 1'b0;
         if (go_r) begin
            branch_decode_enable <= 1'b0;
            erase_head_on <= 1'b0;
         end
         if (tick && !inh && cbr_r) begin
            if (br_r == DESQ_BR_DEC && cond_r) begin
               write_chain_disable <= 1'b1;
               branch_addr_to_mux <= 1'b1;
            end
            if (br_r == DESQ_BR_LOAD) begin
               if (cond_r) begin
                  branch_load <= 1'b1;
                  load_director_address <= 1'b1;
                  branch_flush <= 1'b1;
                  director_address_r <= branch_hold_r;
               end else if (erase_en_r) begin
                  erase_head_on <= 1'b1;
               end
            end
            if (br_r == DESQ_BR_FIN) begin
               branch_finish <= 1'b1;
               write_chain_disable <= 1'b0;
               branch_addr_to_mux <= 1'b0;
               branch_decode_enable <= cond_r;
            end
         end
      end
   end

   // the alu chain runs exactly eight ticks once begun
   alu_len_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick && alu_ph_r == DESQ_PH8 |=> alu_ph_r == 4'd0)
      else $error("alu chain did not end after phase eight");
   capture_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick && alu_ph_r == DESQ_PH5 |=> alu_catch_r == $past(alu_out[15:0]))
      else $error("alu result not captured at phase five");
   flag_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick && alu_ph_r == DESQ_PH6 |=> !add_r && !sub_r)
      else $error("operation flag not cleared at phase six");
   done_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick && alu_ph_r == DESQ_PH7 |=> director_done && done_clr_r)
      else $error("done not raised at phase seven");
   hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      inh && br_r != DESQ_BR_IDLE && br_r != DESQ_BR_CLRC |=> $stable(br_r))
      else $error("branch chain moved while inhibited");
   rd_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      br_r == DESQ_BR_A && catch15_r && rd_busy |=> br_r == DESQ_BR_A)
      else $error("stage a left during read in progress");
   load_a: assert property (@(posedge pclk) disable iff (!presetn)
      branch_load |-> director_address_r == branch_hold_r && branch_flush)
      else $error("branch load without address and flush");
   erase_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(erase_head_on) |-> !cond_r && erase_en_r)
      else $error("erase head on with condition met");
   finish_a: assert property (@(posedge pclk) disable iff (!presetn)
      branch_finish |-> director_done && !cbr_r)
      else $error("finish without done or with branch active");
   term_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(director_run_enable) |-> $past(end_gate_r) && !ready_r)
      else $error("execution stopped without end gate");
endmodule

// ==== inc/desq_pkg.sv ====
// Purpose: shared constants and types for the director execution sequencer
// Assumes: directors numbered bit 00 at the msb, bit 31 at the lsb
// Notes: software view is a small apb register set
package desq_pkg;
   // apb register byte offsets
   localparam logic [7:0] DESQ_OFF_DIR = 8'h00;
   localparam logic [7:0] DESQ_OFF_CTRL = 8'h04;
   localparam logic [7:0] DESQ_OFF_STAT = 8'h08;
   localparam logic [7:0] DESQ_OFF_FLAGS = 8'h0c;
   localparam logic [7:0] DESQ_OFF_RESULT = 8'h10;
   // control register bit positions
   localparam int DESQ_CTRL_START = 0;
   localparam int DESQ_CTRL_RESTART = 1;
   localparam int DESQ_CTRL_INHIBIT = 2;
   localparam int DESQ_CTRL_RD_BUSY = 3;
   // function code that re-enables execution after terminate
   localparam logic [15:0] DESQ_RESTART_CODE = 16'h0022;
   localparam logic [3:0] DESQ_RESTART_CHAN = 4'h8;
   // director opcode field in bits 00-07 (msb end); values arbitrary
   localparam logic [7:0] DESQ_OP_BRANCH = 8'h01;
   localparam logic [7:0] DESQ_OP_TERM = 8'h02;
   localparam logic [7:0] DESQ_OP_SUB = 8'h03;
   localparam logic [7:0] DESQ_OP_ADD = 8'h04;
   // read timing chain step at which terminate acts (read time 300)
   localparam logic [1:0] DESQ_RT300 = 2'd3;
   // alu chain phases
   localparam logic [3:0] DESQ_PH5 = 4'd5;
   localparam logic [3:0] DESQ_PH6 = 4'd6;
   localparam logic [3:0] DESQ_PH7 = 4'd7;
   localparam logic [3:0] DESQ_PH8 = 4'd8;
   // branch chain states
   typedef enum logic [2:0] {
      DESQ_BR_IDLE = 3'b000,
      DESQ_BR_A = 3'b001,
      DESQ_BR_B = 3'b010,
      DESQ_BR_DEC = 3'b011,
      DESQ_BR_LOAD = 3'b100,
      DESQ_BR_FIN = 3'b101,
      DESQ_BR_CLRC = 3'b110
   } desq_br_t;
endpackage

// ==== tb/desq_partner.sv ====
// Purpose: far side model: internal clock pulses and host channel codes
// Assumes: the bench commands it; every change follows a pclk rising edge
// Notes: idle channel lines keep walking so a stale value never matches
`timescale 1ns/1ps
module desq_partner
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick_on,
   input wire logic [1:0] gap,
   input wire logic send,
   input wire logic [3:0] chan,
   input wire logic [15:0] code,
   output logic internal_clock_tick,
   output logic chan_func_valid,
   output logic [3:0] chan_number,
   output logic [15:0] chan_func_code
);
   logic [1:0] wait_r; // cycles since the last pulse
   // pulse train; gap 0 gives back-to-back pulses, larger gaps are slow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_r <= 2'h0;
         internal_clock_tick <= 1'b0;
      end else if (tick_on && wait_r >= gap) begin
         wait_r <= 2'h0;
         internal_clock_tick <= 1'b1;
      end else begin
         wait_r <= wait_r + 2'(tick_on);
         internal_clock_tick <= 1'b0;
      end
   end
   // one-cycle function code from the host, else a changing pattern
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_func_valid <= 1'b0;
         chan_number <= 4'h0;
         chan_func_code <= 16'h0000;
      end else if (send) begin
         chan_func_valid <= 1'b1;
         chan_number <= chan;
         chan_func_code <= code;
      end else begin
         chan_func_valid <= 1'b0;
         chan_number <= ~chan_number;
         chan_func_code <= chan_func_code + 16'h1357;
      end
   end
endmodule

// ==== tb/test_director_exec_sequencer.sv ====
// Purpose: self-checking bench for the director execution sequencer
// Assumes: file entries clear on reset; the slave answers with no waits
// Notes: reads are noted in a queue and judged by a separate monitor
`timescale 1ns/1ps
module test_director_exec_sequencer;
   import desq_pkg::*;
   typedef struct {string name; logic [31:0] data; logic err;} desq_note_t;
   logic pclk = 1'b0; // 100 MHz
   logic presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic tick, tick_on, send, c_valid;
   logic [1:0] gap;
   logic [3:0] inh, chan, c_num; // inh: request, timing a, timing b, read
   logic [6:0] flags;
   logic [15:0] code, c_code, dir_addr, exp_addr, catch_m;
   logic wcd, mux, bld, lda, bfl, ehd, bfin, done, dec, run;
   logic [15:0] file_m [16]; // expected register file
   desq_note_t notes [$]; // reads awaiting judgement
   desq_note_t note;
   int fails, total_checks, i;
   desq_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .internal_clock_tick(tick), .director_request_pending(inh[0]),
      .director_write_timing_a(inh[1]), .director_write_timing_b(inh[2]),
      .read_in_progress(inh[3]), .cond_flags(flags),
      .chan_func_valid(c_valid), .chan_number(c_num),
      .chan_func_code(c_code), .write_chain_disable(wcd),
      .branch_addr_to_mux(mux), .branch_load(bld),
      .load_director_address(lda), .branch_flush(bfl),
      .erase_head_on(ehd), .branch_finish(bfin), .director_done(done),
      .branch_decode_enable(dec), .director_run_enable(run),
      .director_address_r(dir_addr));
   desq_partner i_far (.pclk(pclk), .presetn(presetn), .tick_on(tick_on),
      .gap(gap), .send(send), .chan(chan), .code(code),
      .internal_clock_tick(tick), .chan_func_valid(c_valid),
      .chan_number(c_num), .chan_func_code(c_code));
   always #5 pclk = ~pclk;
   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test;
      if (fails == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one transfer; held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input string n, input logic [7:0] a,
      input logic [31:0] d, input logic err);
      notes.push_back('{n, d, err});
      apb(1'b0, a, 32'h0000_0000);
   endtask
   // load a director and start it with the pulse train paused
   task automatic run_dir(input logic [31:0] w);
      tick_on <= 1'b0;
      apb(1'b1, DESQ_OFF_DIR, w);
      apb(1'b1, DESQ_OFF_CTRL, 32'h0000_0001);
      gap <= 2'($urandom_range(0, 2));
      tick_on <= 1'b1;
   endtask
   // wait for n clock pulses, then let that edge's updates settle
   task automatic ticks(input int n);
      for (int k = 0; k < n; k++) begin
         do @(posedge pclk); while (tick !== 1'b1);
         #1;
      end
   endtask
   task automatic arith(input logic sub, input logic [15:0] op,
      input logic [3:0] ra, input logic live);
      logic [15:0] r;
      r = sub ? file_m[ra] - op : file_m[ra] + op;
      run_dir({sub ? DESQ_OP_SUB : DESQ_OP_ADD, op, 4'h0, ra});
      ticks(7);
      check("done early", 32'(done), 32'h0000_0000);
      ticks(1);
      check("done set", 32'(done), 32'(live));
      ticks(1);
      check("done clear", 32'(done), 32'h0000_0000);
      if (live) begin
         file_m[ra] = r;
         catch_m = r;
      end
      rd("result", DESQ_OFF_RESULT, 32'(catch_m), 1'b0);
   endtask
   // hold: 0..3 selects an inhibit (3 is read with bit 15), 4 none
   task automatic branch(input logic [6:0] sel, input logic [6:0] fl,
      input int hold);
      logic met;
      logic [15:0] ba;
      met = |(sel & fl);
      ba = 16'($urandom);
      flags <= fl;
      inh <= (hold < 4) ? 4'(1 << hold) : 4'h0;
      run_dir({DESQ_OP_BRANCH, sel, hold == 3, ba});
      if (hold < 4) begin
         ticks(4);
         check("held chain", 32'({wcd, done}), 32'h0000_0000);
         inh <= 4'h0;
      end
      ticks(3);
      check("decision", 32'({wcd, mux}), 32'({met, met}));
      ticks(1);
      if (met) exp_addr = ba;
      check("load", 32'({bld, lda, bfl}), 32'({3{met}}));
      check("erase", 32'(ehd), 32'(!met && hold == 3));
      check("address", 32'(dir_addr), 32'(exp_addr));
      ticks(1);
      check("finish", 32'({bfin, done, dec}), 32'({2'h3, met}));
      ticks(1);
      check("clear done", 32'(done), 32'h0000_0000);
      rd("status", DESQ_OFF_STAT, 32'(exp_addr), 1'b0);
   endtask
   // take the oldest note whenever a read completes
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         if (notes.size() == 0) check("unexpected read", 32'h1, 32'h0);
         else begin
            note = notes.pop_front();
            check({note.name, " err"}, 32'(pslverr), 32'(note.err));
            if (!note.err) check(note.name, prdata, note.data);
         end
      end
   end
   // watchdog: the tests need well under a thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      end_of_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, tick_on, send} = 6'h00;
      {paddr, pwdata, gap, inh, chan, flags, code} = '0;
      {fails, total_checks, exp_addr, catch_m} = '0;
      foreach (file_m[j]) file_m[j] = 16'h0000;
      void'($urandom(51));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      check("run at reset", 32'(run), 32'h0000_0001);
      rd("unmapped", 8'h14, 32'h0000_0000, 1'b1);
      apb(1'b1, 8'h18, 32'hffff_ffff);
      rd("status", DESQ_OFF_STAT, 32'h0000_0000, 1'b0);
      for (i = 0; i < 8; i++) begin
         arith(i[0], (i == 0) ? 16'hffff : 16'($urandom),
            4'($urandom_range(0, 3)), 1'b1);
      end
      branch(7'h40, 7'h40, 0); // met, request pending at start
      branch(7'h24, 7'h04, 1); // two selected, one set
      branch(7'h01, 7'h02, 2); // not met
      branch(7'h60, 7'h00, 3); // bit 15 during a read, erase wanted
      branch(7'h7f, 7'h08, 4); // all selected, no hold
      run_dir({DESQ_OP_TERM, 24'h00_0000});
      ticks(3);
      check("run before end", 32'(run), 32'h0000_0001);
      ticks(1);
      check("run after end", 32'(run), 32'h0000_0000);
      arith(1'b0, 16'h0001, 4'h0, 1'b0);
      // wrong code, wrong channel, then the restart code
      for (i = 0; i < 3; i++) begin
         @(posedge pclk);
         send <= 1'b1;
         chan <= (i == 1) ? 4'h7 : DESQ_RESTART_CHAN;
         code <= (i == 0) ? 16'h0023 : DESQ_RESTART_CODE;
         @(posedge pclk);
         send <= 1'b0;
         repeat (4) @(posedge pclk);
         check("restart", 32'(run), 32'(i == 2));
      end
      arith(1'b1, 16'h0002, 4'h1, 1'b1);
      end_of_test();
   end
endmodule
